// ---- hdl/mds_pkg.sv ----
/*
  Sequencer constants: addresses, limits, reset values, codes, timing.
  Assumes one parameter per port access.
*/
// Function
// [RQ1] Signed 32-bit target read by type: none, position, distance, homing method, preset.
// [RQ2] Speed 0..13200 rpm is the move target speed or homing search speed.
// [RQ3] Acceleration zero keeps the active ramp; nonzero replaces it for that entry.
// [RQ4] Deceleration zero keeps the active ramp; nonzero replaces it for that entry.
// [RQ5] Following number 0..15 selects the next entry, used only in sequential mode.
// [RQ6] After movement ends wait the pause time, 0..30000 ms, then entry completes.
// [RQ7] Pause applies only in sequential mode, never in direct selection.
// [RQ8] Automatic condition starts the following entry at once, ignoring start input.
// [RQ9] Edge condition is met on a rising or falling start transition as configured.
// [RQ10] Level condition met while start is low (0-level) or high (1-level).
// [RQ11] Global condition code uses the globally configured condition instead.
// [RQ12] Blended condition does not stop; reaching target moves to the next entry.
// [RQ13] Master selects blending only for absolute moves toward a higher next target; code blends on codes 6 and 7 in sequential mode, any type but none.
// [RQ14] Blend A changes to next speed after reaching target; blend B before.
// [RQ15] Condition codes: 0 rise,1 fall,2 high,3 low,4 global,5 auto,6 blend A,7 blend B.
// [RQ16] Type codes: 0 none, 1 absolute, 2 relative, 3 homing, 4 dimension setting.
// [RQ17] Processing mode 0 selects direct selection, 1 sequential selection.
// [RQ18] Out-of-range parameter writes are rejected and the old value kept.
// [RQ19] Sixteen entries, each with type, target, speed, ramps, pause, next, condition.

`default_nettype none

package mds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter addresses
  localparam logic [15:0] ADDR_PROC_MODE   = 16'h2D0E;
  localparam logic [15:0] ADDR_GLOBAL_COND = 16'h2D10;
  localparam logic [15:0] ADDR_TYPE        = 16'h2D22;
  localparam logic [15:0] ADDR_TARGET      = 16'h2D24;
  localparam logic [15:0] ADDR_SPEED       = 16'h2D26;
  localparam logic [15:0] ADDR_ACCEL       = 16'h2D28;
  localparam logic [15:0] ADDR_DECEL       = 16'h2D2A;
  localparam logic [15:0] ADDR_PAUSE       = 16'h2D2C;
  localparam logic [15:0] ADDR_COND        = 16'h2D2E;
  localparam logic [15:0] ADDR_NEXT        = 16'h2D30;

  ////////////////////////////////////////////////////////////////////////////
  // Field limits
  localparam logic [31:0] SPEED_MAX       = 32'h0000_3390;
  localparam logic [31:0] RAMP_MAX        = 32'h002D_C6C0;
  localparam logic [31:0] PAUSE_MAX_MS    = 32'h0000_7530;
  localparam logic [31:0] NEXT_MAX        = 32'h0000_000F;
  localparam logic [31:0] TYPE_MAX        = 32'h0000_0004;
  localparam logic [31:0] COND_MAX        = 32'h0000_0007;
  localparam logic [31:0] MODE_MAX        = 32'h0000_0001;
  localparam logic [31:0] GLOBAL_COND_MAX = 32'h0000_0003;

  ////////////////////////////////////////////////////////////////////////////
  // Decode codes
  localparam logic [2:0] TYPE_NONE   = 3'h0;
  localparam logic [2:0] TYPE_ABS    = 3'h1;
  localparam logic [2:0] TYPE_REL    = 3'h2;
  localparam logic [2:0] TYPE_HOMING = 3'h3;
  localparam logic [2:0] TYPE_DIM    = 3'h4;

  localparam logic [2:0] COND_RISE   = 3'h0;
  localparam logic [2:0] COND_FALL   = 3'h1;
  localparam logic [2:0] COND_HIGH   = 3'h2;
  localparam logic [2:0] COND_LOW    = 3'h3;
  localparam logic [2:0] COND_GLOBAL = 3'h4;
  localparam logic [2:0] COND_AUTO   = 3'h5;
  localparam logic [2:0] COND_BLENDA = 3'h6;
  localparam logic [2:0] COND_BLENDB = 3'h7;

  localparam logic MODE_DIRECT = 1'b0;
  localparam logic MODE_SEQ    = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic        RST_PROC_MODE   = MODE_SEQ;
  localparam logic [1:0]  RST_GLOBAL_COND = 2'h0;
  localparam logic [2:0]  RST_COND        = COND_GLOBAL;
  localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
  localparam logic [31:0] RAMP_DEFAULT    = 32'h0000_0258;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_FREQ_KHZ   = 250000;
  localparam int PAUSE_UNIT_MS  = 1;
  localparam int CYCLES_PER_MS  = CLK_FREQ_KHZ * PAUSE_UNIT_MS;

endpackage

`default_nettype wire

// ---- hdl/mds_pause_timer.sv ----
/*
  Pause timer: counts delay_ms milliseconds after start, then pulses done.
  Assumes start is a one-cycle pulse while idle.
*/
`default_nettype none

module mds_pause_timer
  import mds_pkg::*;
#(
  parameter int CYC_PER_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        start,
  input  wire logic [15:0] delay_ms,
  output var  logic        done
);

  localparam int PW = $clog2(CYC_PER_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

  logic          run_reg;
  logic [PW-1:0] pre_reg;
  logic [15:0]   ms_reg;

  wire ms_tick  = run_reg && (pre_reg == PRE_LAST);
  wire finished = run_reg && (ms_reg == 16'h0000);

  // Zero pause finishes one cycle after start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      pre_reg <= '0;
      ms_reg  <= 16'h0000;
      done    <= 1'b0;
    end else begin
      done <= finished; // RQ6
      if (start) begin
        run_reg <= 1'b1;
        pre_reg <= '0;
        ms_reg  <= delay_ms;
      end else if (finished) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        pre_reg <= ms_tick ? '0 : pre_reg + 1'b1;
        if (ms_tick) begin
          ms_reg <= ms_reg - 16'h0001;
        end
      end
    end
  end

endmodule // mds_pause_timer

`default_nettype wire

// ---- hdl/mds_sequencer.sv ----
/*
  Motion data set sequencer: entry table on the parameter port,
  entry launch and transition decisions.
  Assumes move_done at standstill, target_reached when passing the target,
  and synchronous inputs.
*/
`default_nettype none

module mds_sequencer
  import mds_pkg::*;
#(
  parameter int ENTRIES    = 16,
  parameter int CYC_PER_MS = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Parameter port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [3:0]  par_entry,
  input  wire logic [31:0] par_wdata,
  output var  logic [31:0] par_rdata,
  output var  logic        par_ack,
  output var  logic        par_err,
  // Sequence control
  input  wire logic        seq_enable,
  input  wire logic [3:0]  start_entry,
  input  wire logic        start_func,
  input  wire logic        move_done,
  input  wire logic        target_reached,
  // Motion command
  output var  logic        cmd_start,
  output var  logic [3:0]  cmd_entry,
  output var  logic [2:0]  cmd_type,
  output var  logic [31:0] cmd_target,
  output var  logic [31:0] homing_method_select,
  output var  logic [15:0] cmd_speed,
  output var  logic [31:0] active_accel_ramp,
  output var  logic [31:0] active_decel_ramp,
  output var  logic        cmd_blend,
  output var  logic [15:0] blend_speed,
  output var  logic        blend_speed_valid,
  // Status
  output var  logic        entry_done,
  output var  logic [3:0]  entry_done_num,
  output var  logic        seq_busy
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MOVE, ST_PAUSE} mds_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Entry table
  logic [2:0]  type_mem  [ENTRIES];
  logic [31:0] tgt_mem   [ENTRIES];
  logic [15:0] spd_mem   [ENTRIES];
  logic [31:0] acc_mem   [ENTRIES];
  logic [31:0] dec_mem   [ENTRIES];
  logic [15:0] pause_mem [ENTRIES];
  logic [3:0]  next_mem  [ENTRIES];
  logic [2:0]  cond_mem  [ENTRIES];

  logic       proc_mode_reg;
  logic [1:0] global_cond_reg;

  wire sel_mode   = (par_addr == ADDR_PROC_MODE);
  wire sel_global = (par_addr == ADDR_GLOBAL_COND);
  wire sel_type   = (par_addr == ADDR_TYPE);
  wire sel_target = (par_addr == ADDR_TARGET);
  wire sel_speed  = (par_addr == ADDR_SPEED);
  wire sel_accel  = (par_addr == ADDR_ACCEL);
  wire sel_decel  = (par_addr == ADDR_DECEL);
  wire sel_pause  = (par_addr == ADDR_PAUSE);
  wire sel_cond   = (par_addr == ADDR_COND);
  wire sel_next   = (par_addr == ADDR_NEXT);
  wire addr_hit   = sel_mode | sel_global | sel_type | sel_target | sel_speed |
                    sel_accel | sel_decel | sel_pause | sel_cond | sel_next;

  // Range check per field; target spans the whole signed range
  wire in_range = (sel_mode   && par_wdata <= MODE_MAX) ||
                  (sel_global && par_wdata <= GLOBAL_COND_MAX) ||
                  (sel_type   && par_wdata <= TYPE_MAX) ||
                  sel_target ||
                  (sel_speed  && par_wdata <= SPEED_MAX) ||
                  (sel_accel  && par_wdata <= RAMP_MAX) ||
                  (sel_decel  && par_wdata <= RAMP_MAX) ||
                  (sel_pause  && par_wdata <= PAUSE_MAX_MS) ||
                  (sel_cond   && par_wdata <= COND_MAX) ||
                  (sel_next   && par_wdata <= NEXT_MAX); // RQ18
  wire wr_ok = par_wr && in_range; // RQ18

  // Each entry is written only when its index matches
  for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
    wire hit = wr_ok && (par_entry == 4'(e));
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        type_mem[e]  <= TYPE_NONE;
        tgt_mem[e]   <= RST_ZERO;
        spd_mem[e]   <= RST_ZERO[15:0];
        acc_mem[e]   <= RST_ZERO;
        dec_mem[e]   <= RST_ZERO;
        pause_mem[e] <= RST_ZERO[15:0];
        next_mem[e]  <= RST_ZERO[3:0];
        cond_mem[e]  <= RST_COND;
      end else if (hit) begin // RQ19
        if (sel_type)   type_mem[e]  <= par_wdata[2:0];
        if (sel_target) tgt_mem[e]   <= par_wdata;
        if (sel_speed)  spd_mem[e]   <= par_wdata[15:0];
        if (sel_accel)  acc_mem[e]   <= par_wdata;
        if (sel_decel)  dec_mem[e]   <= par_wdata;
        if (sel_pause)  pause_mem[e] <= par_wdata[15:0];
        if (sel_next)   next_mem[e]  <= par_wdata[3:0];
        if (sel_cond)   cond_mem[e]  <= par_wdata[2:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      proc_mode_reg   <= RST_PROC_MODE;
      global_cond_reg <= RST_GLOBAL_COND;
    end else if (wr_ok) begin
      if (sel_mode)   proc_mode_reg   <= par_wdata[0];
      if (sel_global) global_cond_reg <= par_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  wire [31:0] rd_value =
    sel_mode   ? {31'h0000_0000, proc_mode_reg} :
    sel_global ? {30'h0000_0000, global_cond_reg} :
    sel_type   ? {29'h0000_0000, type_mem[par_entry]} :
    sel_target ? tgt_mem[par_entry] :
    sel_speed  ? {16'h0000, spd_mem[par_entry]} :
    sel_accel  ? acc_mem[par_entry] :
    sel_decel  ? dec_mem[par_entry] :
    sel_pause  ? {16'h0000, pause_mem[par_entry]} :
    sel_cond   ? {29'h0000_0000, cond_mem[par_entry]} :
    sel_next   ? {28'h0000_000, next_mem[par_entry]} :
    RST_ZERO;

  // Rejected writes and unmapped reads answer with an error flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
      par_rdata <= RST_ZERO;
    end else begin
      par_ack <= par_wr | par_rd;
      par_err <= (par_wr & ~in_range) | (par_rd & ~addr_hit); // RQ18
      if (par_rd) begin
        par_rdata <= rd_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transition condition evaluation
  mds_state_t st_reg;
  mds_state_t st_next;
  logic       seq_reg;
  logic [3:0] cur_reg;
  logic [2:0] pend_reg;
  logic       blend_reg;
  logic       start_prev_reg;

  wire start_rise = start_func & ~start_prev_reg;
  wire start_fall = ~start_func & start_prev_reg;

  // Global code is replaced by the global setting before decoding
  wire [2:0] eff_cond = (pend_reg == COND_GLOBAL) ? {1'b0, global_cond_reg} : pend_reg; // RQ11

  logic cond_ok;
  always_comb begin
    cond_ok = 1'b0;
    case (eff_cond) // RQ15
      COND_RISE: cond_ok = start_rise;  // RQ9
      COND_FALL: cond_ok = start_fall;  // RQ9
      COND_HIGH: cond_ok = start_func;  // RQ10
      COND_LOW:  cond_ok = ~start_func; // RQ10
      COND_AUTO: cond_ok = 1'b1;        // RQ8
      default:   cond_ok = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch selection
  // Direct mode triggers start_entry on a rising edge
  wire        launch_wait  = (st_reg == ST_WAIT) && cond_ok;
  wire        launch_blend = (st_reg == ST_MOVE) && blend_reg && target_reached; // RQ12
  wire        launch       = launch_wait | launch_blend;
  wire [3:0]  seq_next_idx = next_mem[cur_reg]; // RQ5
  wire [3:0]  launch_idx   = launch_blend ? seq_next_idx : (seq_reg ? cur_reg : start_entry);
  wire [2:0]  l_type       = type_mem[launch_idx];
  wire [2:0]  l_cond       = cond_mem[launch_idx];
  wire [3:0]  l_next       = next_mem[launch_idx];
  wire        l_blend      = seq_reg && (l_cond == COND_BLENDA || l_cond == COND_BLENDB); // RQ12
  wire        l_none       = (l_type == TYPE_NONE); // RQ16
  wire        move_end     = (st_reg == ST_MOVE) && !blend_reg && move_done;

  // Pause runs only for sequential processing
  wire        pause_start  = seq_reg && (move_end || (launch && l_none)); // RQ7
  wire [15:0] pause_ms     = (launch && l_none) ? pause_mem[launch_idx] : pause_mem[cur_reg];
  wire        pause_done;
  wire        direct_done  = !seq_reg && (move_end || (launch && l_none)); // RQ7

  mds_pause_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_pause (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .start    (pause_start),
    .delay_ms (pause_ms),
    .done     (pause_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state machine
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE:  if (seq_enable) st_next = ST_WAIT;
      ST_WAIT:  if (launch) st_next = l_none ? (seq_reg ? ST_PAUSE : ST_WAIT) : ST_MOVE;
      ST_MOVE: begin
        if (launch_blend) begin
          st_next = l_none ? ST_PAUSE : ST_MOVE;
        end else if (move_end) begin
          st_next = seq_reg ? ST_PAUSE : ST_WAIT; // RQ7
        end
      end
      ST_PAUSE: if (pause_done) st_next = ST_WAIT; // RQ6
      default:  st_next = ST_IDLE;
    endcase
    if (!seq_enable) begin
      st_next = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg         <= ST_IDLE;
      seq_reg        <= MODE_SEQ;
      cur_reg        <= 4'h0;
      pend_reg       <= COND_RISE;
      blend_reg      <= 1'b0;
      start_prev_reg <= 1'b0;
      seq_busy       <= 1'b0;
    end else begin
      st_reg         <= st_next;
      start_prev_reg <= start_func;
      seq_busy       <= (st_next != ST_IDLE);
      if (st_reg == ST_IDLE && seq_enable) begin
        seq_reg  <= proc_mode_reg; // RQ17
        cur_reg  <= start_entry;
        pend_reg <= (proc_mode_reg == MODE_SEQ) ? COND_GLOBAL : COND_RISE; // RQ11
      end else if (launch) begin
        cur_reg   <= launch_idx;
        blend_reg <= l_blend && !l_none;
      end else if (pause_done) begin
        // Completed entry hands its own condition to the following one
        cur_reg  <= seq_next_idx;     // RQ5
        pend_reg <= cond_mem[cur_reg];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion command outputs
  wire [15:0] l_next_speed = spd_mem[l_next];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_start            <= 1'b0;
      cmd_entry            <= 4'h0;
      cmd_type             <= TYPE_NONE;
      cmd_target           <= RST_ZERO;
      homing_method_select <= RST_ZERO;
      cmd_speed            <= RST_ZERO[15:0];
      cmd_blend            <= 1'b0;
    end else begin
      cmd_start <= launch && !l_none;
      if (launch && !l_none) begin
        cmd_entry  <= launch_idx;
        cmd_type   <= l_type;
        cmd_target <= tgt_mem[launch_idx]; // RQ1
        cmd_speed  <= spd_mem[launch_idx]; // RQ2
        cmd_blend  <= l_blend;
        if (l_type == TYPE_HOMING) begin
          homing_method_select <= tgt_mem[launch_idx]; // RQ1
        end
      end
    end
  end

  // Zero ramp fields leave the ramp in force from the previous entry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_accel_ramp <= RAMP_DEFAULT;
      active_decel_ramp <= RAMP_DEFAULT;
    end else if (launch && !l_none) begin
      if (acc_mem[launch_idx] != RST_ZERO) active_accel_ramp <= acc_mem[launch_idx]; // RQ3
      if (dec_mem[launch_idx] != RST_ZERO) active_decel_ramp <= dec_mem[launch_idx]; // RQ4
    end
  end

  // Type B announces the next speed at launch, type A only at the target
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blend_speed       <= RST_ZERO[15:0];
      blend_speed_valid <= 1'b0;
    end else if (launch && l_blend && l_cond == COND_BLENDB) begin
      blend_speed       <= l_next_speed; // RQ14
      blend_speed_valid <= 1'b1;
    end else if (launch_blend) begin
      blend_speed       <= spd_mem[seq_next_idx]; // RQ14
      blend_speed_valid <= 1'b1;
    end else if (st_reg != ST_MOVE) begin
      blend_speed_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion report
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      entry_done     <= 1'b0;
      entry_done_num <= 4'h0;
    end else begin
      entry_done <= pause_done | direct_done | launch_blend; // RQ6
      if (pause_done || move_end || launch_blend) begin
        entry_done_num <= cur_reg;
      end else if (direct_done) begin
        entry_done_num <= launch_idx;
      end
    end
  end

endmodule // mds_sequencer

`default_nettype wire

// ---- verif/mds_checker.sv ----
/*
  Checker for mds_sequencer: port handshake, refusal, launch type, ramps.
  Assumes it is bound into mds_sequencer and sees only its ports.
*/
`default_nettype none

module mds_checker
  import mds_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Parameter port
  input wire logic        par_wr,
  input wire logic        par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  input wire logic [31:0] par_rdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  // Motion command
  input wire logic        cmd_start,
  input wire logic [2:0]  cmd_type,
  input wire logic [31:0] active_accel_ramp,
  input wire logic [31:0] active_decel_ramp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    par_wr || par_rd;
  endsequence
  sequence s_wr_above(logic [15:0] a, logic [31:0] mx);
    par_wr && par_addr == a && par_wdata > mx;
  endsequence

  a_ack_follows: assert property (s_req |=> par_ack)
    else $error("ack missing after access");
  a_ack_only_req: assert property (!(par_wr || par_rd) |=> !par_ack)
    else $error("ack without access");
  a_rdata_holds: assert property (!par_rd |=> $stable(par_rdata))
    else $error("read data moved without read");
  a_bad_speed: assert property (s_wr_above(ADDR_SPEED, SPEED_MAX) |=> par_err)
    else $error("speed above limit accepted");
  a_bad_accel: assert property (s_wr_above(ADDR_ACCEL, RAMP_MAX) |=> par_err)
    else $error("acceleration above limit accepted");
  a_bad_pause: assert property (s_wr_above(ADDR_PAUSE, PAUSE_MAX_MS) |=> par_err)
    else $error("pause above limit accepted");
  a_launch_typed: assert property (cmd_start |-> cmd_type inside {[TYPE_ABS:TYPE_DIM]})
    else $error("launch with no movement type");
  a_accel_at_launch: assert property ($changed(active_accel_ramp) |-> cmd_start)
    else $error("acceleration changed outside a launch");
  a_decel_at_launch: assert property ($changed(active_decel_ramp) |-> cmd_start)
    else $error("deceleration changed outside a launch");
endmodule // mds_checker

bind mds_sequencer mds_checker u_chk (
  .mclk, .rst_n, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata, .par_ack, .par_err,
  .cmd_start, .cmd_type, .active_accel_ramp, .active_decel_ramp
);

`default_nettype wire

// ---- verif/mds_master_model.sv ----
/*
  Fieldbus master model: one access per call, answer taken a cycle later.
  Assumes calls do not overlap.
*/
`default_nettype none

module mds_master_model
  import mds_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Parameter port
  output var  logic        par_wr,
  output var  logic        par_rd,
  output var  logic [15:0] par_addr,
  output var  logic [3:0]  par_entry,
  output var  logic [31:0] par_wdata,
  input  wire logic [31:0] par_rdata,
  input  wire logic        par_ack,
  input  wire logic        par_err
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {par_wr, par_rd, par_addr, par_entry, par_wdata} = '0;
  // Data is inverted once released so a stale bus never matches
  task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] k,
                      input logic [31:0] v, output logic [31:0] q, output logic err);
    @(posedge mclk);
    {par_wr, par_rd} <= {w, !w};
    par_addr <= a;
    par_entry <= k;
    par_wdata <= v;
    @(posedge mclk);
    {par_wr, par_rd} <= 2'b00;
    par_wdata <= ~v;
    @(negedge mclk);
    q = par_rdata;
    err = (par_ack === 1'b1) ? par_err : 1'bx;
  endtask
endmodule // mds_master_model

`default_nettype wire

// ---- verif/tb.sv ----
/*
  Bench for mds_sequencer: table, refusal, sequential, blended and direct runs.
  Assumes the master model owns the parameter port.
*/
`default_nettype none

module tb
  import mds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 4;
  logic        mclk, rst_n, seq_enable, start_func, move_done, target_reached;
  logic        par_wr, par_rd, par_ack, par_err, e, hit, cmd_start, cmd_blend, bsv, entry_done, busy;
  logic [3:0]  start_entry, par_entry, cmd_entry, done_num;
  logic [2:0]  cmd_type;
  logic [15:0] par_addr, cmd_speed, bsp, sp;
  logic [31:0] par_wdata, par_rdata, q, tg, ac, cmd_target, hms, acc_r, dec_r;
  logic [31:0] shadow [16][10];
  logic [15:0] addrs [10] = '{ADDR_PROC_MODE, ADDR_GLOBAL_COND, ADDR_TYPE, ADDR_TARGET, ADDR_SPEED,
                              ADDR_ACCEL, ADDR_DECEL, ADDR_PAUSE, ADDR_COND, ADDR_NEXT};
  int          n_fail, cmp_count, n, i;

  mds_sequencer #(.ENTRIES(16), .CYC_PER_MS(CPM)) DUT (
    .mclk, .rst_n, .par_wr, .par_rd, .par_addr, .par_entry, .par_wdata, .par_rdata, .par_ack, .par_err,
    .seq_enable, .start_entry, .start_func, .move_done, .target_reached, .cmd_start, .cmd_entry, .cmd_type,
    .cmd_target, .homing_method_select(hms), .cmd_speed, .active_accel_ramp(acc_r), .active_decel_ramp(dec_r),
    .cmd_blend, .blend_speed(bsp), .blend_speed_valid(bsv), .entry_done, .entry_done_num(done_num),
    .seq_busy(busy));
  mds_master_model u_master (.mclk, .par_wr, .par_rd, .par_addr, .par_entry, .par_wdata, .par_rdata,
    .par_ack, .par_err);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lim(input int k);
    logic [31:0] t [10] = '{32'h1, 32'h3, 32'h4, 32'hFFFF_FFFF, 32'd13200,
                            32'd3000000, 32'd3000000, 32'd30000, 32'h7, 32'hF};
    return t[k];
  endfunction
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Shadow copy follows only accepted writes
  task automatic wrrd(input int k, input logic [3:0] x, input logic [31:0] v);
    logic bad;
    bad = (k != 3) && (v > lim(k));
    if (k < 2) x = 4'h0;
    u_master.xfer(1'b1, addrs[k], x, v, q, e);
    chk(e === bad, "write refusal flag");
    if (!bad) shadow[x][k] = v;
    u_master.xfer(1'b0, addrs[k], x, 32'h0, q, e);
    chk(q === shadow[x][k] && e === 1'b0, "readback");
  endtask
  task automatic cfg(input logic [3:0] x, input int ty, tgt, spd, a, d, p, c, nx);
    int v [8];
    v = '{ty, tgt, spd, a, d, p, c, nx};
    foreach (v[j]) wrrd(j + 2, x, v[j]);
  endtask
  task automatic wait_ev(input bit dn, input int mx);
    n = 0;
    hit = 0;
    while (!hit && n < mx) begin
      @(negedge mclk);
      n++;
      hit = ((dn ? entry_done : cmd_start) === 1'b1);
    end
  endtask
  task automatic pulse_done();
    @(posedge mclk) move_done <= 1'b1;
    @(posedge mclk) move_done <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Whole run is several hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
  initial begin
    {rst_n, seq_enable, move_done, target_reached, start_entry} = '0;
    start_func = 1'b1;
    void'($urandom(87));
    foreach (shadow[x, k]) shadow[x][k] = (k == 0) ? 32'h1 : (k == 8) ? 32'h4 : 32'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chk(acc_r === RAMP_DEFAULT && dec_r === RAMP_DEFAULT && busy === 1'b0, "reset outputs");
    for (i = 0; i < 10; i++) begin
      u_master.xfer(1'b0, addrs[i], 4'($urandom), 32'h0, q, e);
      chk(q === shadow[0][i], "reset value");
    end
    for (i = 0; i < 10; i++) begin
      wrrd(i, 4'hF, (i == 3) ? 32'h8000_0000 : lim(i));
      wrrd(i, 4'hF, (i == 3) ? 32'h7FFF_FFFF : lim(i) + 1);
    end
    repeat (60) begin
      i = $urandom_range(9);
      wrrd(i, 4'($urandom), (i == 3) ? $urandom : $urandom_range(lim(i) + 3, 0));
    end
    u_master.xfer(1'b0, 16'h0000, 4'h0, 32'h0, q, e);
    chk(e === 1'b1, "unmapped read");
    // Sequential run, global falling edge starts entry 0
    tg = $urandom;
    sp = 16'($urandom_range(13200));
    ac = $urandom_range(3000000, 1);
    wrrd(0, 0, 1);
    wrrd(1, 0, 1);
    cfg(0, 1, tg, sp, ac, 0, 1, 5, 2);
    cfg(2, 2, $urandom, 0, 0, 0, 0, 2, 7);
    cfg(7, 3, 5, 100, 0, 0, 0, 4, 9);
    cfg(9, 1, 100, 50, 0, ac, 0, 6, 10);
    cfg(10, 1, 200, sp, 0, 0, 0, 5, 0);
    @(posedge mclk) seq_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    start_func <= 1'b0;
    wait_ev(0, 10);
    chk(hit && cmd_entry === 4'd0 && cmd_type === TYPE_ABS && cmd_target === tg, "global start");
    chk(cmd_speed === sp && acc_r === ac && dec_r === RAMP_DEFAULT, "entry profile");
    pulse_done();
    wait_ev(1, 40);
    chk(hit && n >= CPM && n <= CPM + 4 && done_num === 4'd0, "pause length");
    wait_ev(0, 4);
    chk(hit && cmd_entry === 4'd2 && cmd_type === TYPE_REL, "auto step");
    chk(acc_r === ac && dec_r === RAMP_DEFAULT, "zero ramps keep active");
    pulse_done();
    wait_ev(1, 6);
    chk(hit && done_num === 4'd2, "zero pause");
    wait_ev(0, 10);
    chk(!hit, "high level not met");
    @(posedge mclk) start_func <= 1'b1;
    wait_ev(0, 6);
    chk(hit && cmd_entry === 4'd7 && hms === 32'd5, "high level met");
    pulse_done();
    wait_ev(1, 6);
    @(posedge mclk) start_func <= 1'b0;
    wait_ev(0, 6);
    chk(hit && cmd_entry === 4'd9 && cmd_blend && !bsv && dec_r === ac, "blend launch");
    @(posedge mclk) target_reached <= 1'b1;
    wait_ev(0, 4);
    chk(hit && cmd_entry === 4'd10 && entry_done && done_num === 4'd9, "blend step");
    chk(bsv && bsp === sp, "blend A speed");
    @(posedge mclk) seq_enable <= 1'b0;
    target_reached <= 1'b0;
    // Direct run: long pause must not delay completion
    wrrd(0, 0, 0);
    cfg(5, 4, tg, sp, 0, 0, 50, 3, 9);
    @(posedge mclk) start_entry <= 4'd5;
    seq_enable <= 1'b1;
    repeat (3) @(posedge mclk);
    start_func <= 1'b1;
    wait_ev(0, 10);
    chk(hit && cmd_entry === 4'd5 && cmd_type === TYPE_DIM && busy, "direct launch");
    pulse_done();
    wait_ev(1, 4);
    chk(hit && done_num === 4'd5, "direct ignores pause");
    stop_test();
  end
endmodule // tb

`default_nettype wire
